// [src/two_wire_port.v]
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "tw_regs.vh"
// How it works
// - arbitration loss drops to idle, lines released
// - clock high phase waits for wired SCL
// - stop driving SDA when loss seen
// - writing one clears done flag
// - no bus step while done flag set
// - start done gives code 08
// - repeated start gives 10, address sent
// - write address ack 18, nack 20; read address ack 40
// - data ack 28, nack 30
// - begin/end bits pick data, restart, stop
// - loss gives 38; begin queues start
// - master only entered by start
// - one data register for address, data
// - restart keeps bus without stop
// - read bit high, ack low
module two_wire_port
(
   input wire CLK,
   input wire NRST,
   input wire [3:0] AVS_ADDRESS,
   input wire AVS_READ,
   input wire AVS_WRITE,
   input wire [31:0] AVS_WRITEDATA,
   output reg [31:0] AVS_READDATA,
   output reg AVS_WAITREQUEST,
   input wire SCL_IN,
   output reg SCL_OUT,
   output reg SCL_OE_N,
   input wire SDA_IN,
   output reg SDA_OUT,
   output reg SDA_OE_N,
   output reg IRQ
);
// ************************************************
// states
// ************************************************
localparam S_IDLE = 3'd0;
localparam S_START = 3'd1;
localparam S_BIT = 3'd2;
localparam S_ACK = 3'd3;
localparam S_STOP = 3'd4;
localparam S_HOLD = 3'd5;
localparam P_LO = 2'd0;
localparam P_HI = 2'd1;
localparam P_END = 2'd2;
reg [2:0] state_r;
reg [1:0] ph_r;
reg [7:0] cnt_r;
reg [2:0] bit_r;
reg [7:0] shift_r;
reg addr_r;
reg rx_r;
reg owner_r;
reg busy_r;
reg pend_start_r;
reg [7:0] ctrl_r;
reg [7:0] code_r;
reg [7:0] data_r;
reg [7:0] rate_r;
reg [2:0] ist_r;
reg [2:0] imask_r;
reg power_off_r;
reg scl_drv_r;
reg sda_drv_r;
reg go_r;
reg acc_r;
wire scl_s;
wire sda_s;
reg scl_d_r;
reg sda_d_r;
wire sel_ctrl = AVS_WRITE && AVS_ADDRESS == `A_CONTROL;
wire run = ctrl_r[`C_ENABLE] && !power_off_r;
wire tick = cnt_r == 8'h00;
wire stop_seen = scl_s && scl_d_r && sda_s && !sda_d_r;
wire start_seen = scl_s && scl_d_r && !sda_s && sda_d_r;
pin_sync u_scl (.clk(CLK), .nrst(NRST), .d(SCL_IN), .q(scl_s));
pin_sync u_sda (.clk(CLK), .nrst(NRST), .d(SDA_IN), .q(sda_s));
// ************************************************
// shared helpers
// ************************************************
function [7:0] rd_mux;
   input [3:0] a;
   begin
      case (a)
      `A_CONTROL: rd_mux = ctrl_r;
      `A_STATUS: rd_mux = code_r & `CODE_MASK;
      `A_DATA: rd_mux = data_r;
      `A_BITRATE: rd_mux = rate_r;
      `A_IRQ_STAT: rd_mux = {5'h00, ist_r};
      `A_IRQ_MASK: rd_mux = {5'h00, imask_r};
      `A_POWER: rd_mux = {7'h00, power_off_r};
      default: rd_mux = 8'h00;
      endcase
   end
endfunction
// ************************************************
// avalon slave, one wait cycle per access
// ************************************************
always @(posedge CLK or negedge NRST)
begin
   if (!NRST)
   begin
      acc_r <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h00000000;
   end
   else
   begin
      acc_r <= (AVS_READ || AVS_WRITE) && !acc_r;
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !acc_r);
      if (AVS_READ && !acc_r)
         AVS_READDATA <= {24'h000000, rd_mux(AVS_ADDRESS)};
   end
end
wire wr = AVS_WRITE && acc_r;
// ************************************************
// registers and bus engine
// ************************************************
always @(posedge CLK or negedge NRST)
begin
   if (!NRST)
   begin
      state_r <= S_IDLE;
      ph_r <= P_LO;
      cnt_r <= 8'h00;
      bit_r <= 3'd0;
      shift_r <= 8'h00;
      addr_r <= 1'b0;
      rx_r <= 1'b0;
      owner_r <= 1'b0;
      busy_r <= 1'b0;
      pend_start_r <= 1'b0;
      ctrl_r <= 8'h00;
      code_r <= `ST_IDLE;
      data_r <= 8'hFF;
      rate_r <= `BITRATE_RST;
      ist_r <= 3'b000;
      imask_r <= 3'b000;
      power_off_r <= 1'b1;
      scl_drv_r <= 1'b1;
      sda_drv_r <= 1'b1;
      go_r <= 1'b0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
   end
   else
   begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      go_r <= 1'b0;
      if (start_seen)
         busy_r <= 1'b1;
      if (stop_seen)
         busy_r <= 1'b0;
      cnt_r <= tick ? rate_r : cnt_r - 8'h01;
      if (wr && AVS_ADDRESS == `A_DATA)
         data_r <= AVS_WRITEDATA[7:0];
      if (wr && AVS_ADDRESS == `A_BITRATE)
         rate_r <= AVS_WRITEDATA[7:0];
      if (wr && AVS_ADDRESS == `A_IRQ_MASK)
         imask_r <= AVS_WRITEDATA[2:0];
      if (wr && AVS_ADDRESS == `A_POWER)
         power_off_r <= AVS_WRITEDATA[0];
      if (wr && AVS_ADDRESS == `A_IRQ_STAT)
         ist_r <= ist_r & ~AVS_WRITEDATA[2:0];
      if (wr && sel_ctrl)
      begin
         ctrl_r[6:0] <= AVS_WRITEDATA[6:0];
         if (AVS_WRITEDATA[`C_DONE])
         begin
            ctrl_r[`C_DONE] <= 1'b0;
            go_r <= 1'b1;
         end
      end
      case (state_r)
      S_IDLE:
      begin
         // owner keeps scl low so the next step cannot make a stray clock
         scl_drv_r <= !owner_r;
         sda_drv_r <= owner_r ? sda_drv_r : 1'b1;
         if ((go_r || pend_start_r) && run && !ctrl_r[`C_DONE])
         begin
            if (ctrl_r[`C_END] && owner_r)
            begin
               state_r <= S_STOP;
               ph_r <= P_LO;
            end
            else if (ctrl_r[`C_BEGIN] && (owner_r || !busy_r))
            begin
               pend_start_r <= 1'b0;
               state_r <= S_START;
               ph_r <= P_LO;
            end
            else if (ctrl_r[`C_BEGIN])
               pend_start_r <= 1'b1;
            else if (owner_r && go_r)
            begin
               shift_r <= data_r;
               bit_r <= 3'd7;
               state_r <= S_BIT;
               ph_r <= P_LO;
            end
         end
      end
      S_START:
      if (tick)
      begin
         case (ph_r)
         P_LO:
         begin
            // restart releases sda and scl in the same step
            sda_drv_r <= 1'b1;
            scl_drv_r <= 1'b1;
            ph_r <= P_HI;
         end
         P_HI:
         if (scl_s)
         begin
            sda_drv_r <= 1'b0;
            ph_r <= P_END;
         end
         default:
         begin
            scl_drv_r <= 1'b0;
            state_r <= S_HOLD;
            addr_r <= 1'b1;
            ctrl_r[`C_DONE] <= 1'b1;
            ist_r[0] <= 1'b1;
            code_r <= owner_r ? `ST_RSTART : `ST_START;
            owner_r <= 1'b1;
         end
         endcase
      end
      S_BIT, S_ACK:
      if (tick)
      begin
         case (ph_r)
         P_LO:
         begin
            scl_drv_r <= 1'b0;
            sda_drv_r <= (state_r == S_BIT) ? shift_r[bit_r] : 1'b1;
            ph_r <= P_HI;
         end
         P_HI:
         begin
            scl_drv_r <= 1'b1;
            ph_r <= P_END;
         end
         default:
         if (scl_s)
         begin
            scl_drv_r <= 1'b0;
            ph_r <= P_LO;
            if (state_r == S_BIT && sda_drv_r && !sda_s)
            begin
               sda_drv_r <= 1'b1;
               scl_drv_r <= 1'b1;
               owner_r <= 1'b0;
               state_r <= S_IDLE;
               ctrl_r[`C_DONE] <= 1'b1;
               ist_r[2] <= 1'b1;
               code_r <= `ST_ARB;
            end
            else if (state_r == S_BIT)
            begin
               if (bit_r == 3'd0)
                  state_r <= S_ACK;
               bit_r <= bit_r - 3'd1;
            end
            else
            begin
               state_r <= S_HOLD;
               ctrl_r[`C_DONE] <= 1'b1;
               ist_r[0] <= 1'b1;
               addr_r <= 1'b0;
               rx_r <= addr_r && shift_r[0];
               if (addr_r && shift_r[0])
                  code_r <= sda_s ? `ST_IDLE : `ST_MR_ACK;
               else if (addr_r)
                  code_r <= sda_s ? `ST_AW_NACK : `ST_AW_ACK;
               else
                  code_r <= sda_s ? `ST_D_NACK : `ST_D_ACK;
            end
         end
         endcase
      end
      S_STOP:
      if (tick)
      begin
         case (ph_r)
         P_LO:
         begin
            scl_drv_r <= 1'b0;
            sda_drv_r <= 1'b0;
            ph_r <= P_HI;
         end
         P_HI:
         begin
            scl_drv_r <= 1'b1;
            if (scl_s)
               ph_r <= P_END;
         end
         default:
         begin
            sda_drv_r <= 1'b1;
            owner_r <= 1'b0;
            ctrl_r[`C_END] <= 1'b0;
            code_r <= `ST_IDLE;
            state_r <= ctrl_r[`C_BEGIN] ? S_START : S_IDLE;
            ist_r[1] <= 1'b1;
            ph_r <= P_LO;
         end
         endcase
      end
      default:
      begin
         // hold scl low until software acts
         scl_drv_r <= 1'b0;
         state_r <= S_IDLE;
      end
      endcase
      if (!run)
      begin
         state_r <= S_IDLE;
         owner_r <= 1'b0;
         pend_start_r <= 1'b0;
         scl_drv_r <= 1'b1;
         sda_drv_r <= 1'b1;
      end
   end
end
// ************************************************
// pins and interrupt
// ************************************************
always @(posedge CLK or negedge NRST)
begin
   if (!NRST)
   begin
      SCL_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
      SCL_OE_N <= 1'b1;
      SDA_OE_N <= 1'b1;
      IRQ <= 1'b0;
   end
   else
   begin
      // open drain: only ever pull low
      SCL_OE_N <= scl_drv_r && !(state_r == S_IDLE && owner_r);
      SDA_OE_N <= sda_drv_r;
      IRQ <= |(ist_r & imask_r);
   end
end
endmodule // two_wire_port

// [src/tw_regs.vh]
`ifndef TW_REGS_VH
`define TW_REGS_VH
// ************************************************
// register word addresses (consecutive)
// ************************************************
`define A_CONTROL 4'h0
`define A_STATUS 4'h1
`define A_DATA 4'h2
`define A_BITRATE 4'h3
`define A_IRQ_STAT 4'h4
`define A_IRQ_MASK 4'h5
`define A_POWER 4'h6
// ************************************************
// control fields
// ************************************************
`define C_DONE 7
`define C_ACKEN 6
`define C_BEGIN 5
`define C_END 4
`define C_ENABLE 2
// ************************************************
// status codes and reset values
// ************************************************
`define ST_START 8'h08
`define ST_RSTART 8'h10
`define ST_AW_ACK 8'h18
`define ST_AW_NACK 8'h20
`define ST_D_ACK 8'h28
`define ST_D_NACK 8'h30
`define ST_ARB 8'h38
`define ST_MR_ACK 8'h40
`define ST_IDLE 8'hF8
`define CODE_MASK 8'hF8
`define BITRATE_RST 8'h04
`define POWER_RST 8'h01
`endif

// [src/pin_sync.v]
`timescale 1ns/1ps
// ************************************************
// two flop synchroniser for bus lines
// ************************************************
module pin_sync
(
   input wire clk,
   input wire nrst,
   input wire d,
   output reg q
);
reg s1_r;
always @(posedge clk or negedge nrst)
begin
   if (!nrst)
   begin
      s1_r <= 1'b1;
      q <= 1'b1;
   end
   else
   begin
      s1_r <= d;
      q <= s1_r;
   end
end
endmodule // pin_sync

// [bench/bus_slave_model.sv]
`timescale 1ns/1ps
// ****
// slave receiver
// ****
module bus_slave_model
(
   input wire scl,
   input wire sda,
   input wire ack_on,
   output logic sda_oe_n = 1'b1,
   output logic [7:0] byte_seen = 8'h00
);
   logic [3:0] bits = 4'h0;
   // start or restart begins a byte
   always @(negedge sda)
      if (scl) bits = 4'h0;
   always @(posedge scl)
   begin
      if (bits < 4'h8) byte_seen = {byte_seen[6:0], sda};
      bits = bits + 4'h1;
   end
   always @(negedge scl)
   begin
      sda_oe_n = !(bits == 4'h8 && ack_on);
      if (bits == 4'h9) bits = 4'h0;
   end
endmodule // bus_slave_model

// [bench/two_wire_port_props.sv]
`timescale 1ns/1ps
// ****
// port checker
// ****
module tw_props
(
   input wire CLK,
   input wire NRST,
   input wire [3:0] AVS_ADDRESS,
   input wire AVS_READ,
   input wire AVS_WRITE,
   input wire [31:0] AVS_WRITEDATA,
   input wire [31:0] AVS_READDATA,
   input wire AVS_WAITREQUEST,
   input wire SCL_OUT,
   input wire SCL_OE_N,
   input wire SDA_OUT,
   input wire SDA_OE_N,
   input wire IRQ
);
   wire ans = !AVS_WAITREQUEST;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);
   a_bus_answer: assert property ((AVS_READ || AVS_WRITE) && !ans |-> ##[1:2] ans)
      else $error("no answer");
   a_answer_once: assert property (ans |=> !ans)
      else $error("long answer");
   a_status_masked: assert property (AVS_READ && ans && AVS_ADDRESS == 4'h1 |-> AVS_READDATA[2:0] == 3'h0)
      else $error("status bits");
   a_unmapped_zero: assert property (AVS_READ && ans && AVS_ADDRESS > 4'h6 |-> AVS_READDATA == 32'h0)
      else $error("unmapped data");
   a_open_drain: assert property (SCL_OUT == 1'b0 && SDA_OUT == 1'b0)
      else $error("line driven high");
   a_scl_high_min: assert property ($rose(SCL_OE_N) |-> SCL_OE_N [*4])
      else $error("short high phase");
   a_begin_starts: assert property (AVS_WRITE && ans && AVS_ADDRESS == 4'h0 && AVS_WRITEDATA[7:0] == 8'hA4
      |-> ##[1:60] $fell(SDA_OE_N))
      else $error("no start");
   a_reset_idle: assert property ($rose(NRST) |-> SCL_OE_N && SDA_OE_N && !IRQ)
      else $error("busy after reset");
endmodule // tw_props
bind two_wire_port tw_props u_props
(
   .CLK(CLK), .NRST(NRST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .SCL_OUT(SCL_OUT), .SCL_OE_N(SCL_OE_N), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .IRQ(IRQ)
);

// [bench/two_wire_port_tb_top.sv]
`timescale 1ns/1ps
`include "tw_regs.vh"
// ****
// bus port bench
// ****
module two_wire_port_tb_top;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [3:0] adr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic ack_on = 1'b1;
   logic rival = 1'b0;
   logic [31:0] q;
   logic [31:0] rows [0:10];
   wire [31:0] rdat;
   wire [7:0] seen;
   wire wreq, scl_o, scl, sda_o, sda_oe_n, irq, s_oe_n;
   // pull-up: any party may hold the line low
   wire sda = sda_oe_n & s_oe_n & !rival;
   int fails = 0;
   int checks_done = 0;
   int cyc = 0;
   always #50 clk = ~clk;
   two_wire_port u_dut
   (
      .CLK(clk), .NRST(nrst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
      .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .SCL_IN(scl), .SCL_OUT(scl_o), .SCL_OE_N(scl),
      .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_N(sda_oe_n), .IRQ(irq)
   );
   bus_slave_model u_slave (.scl(scl), .sda(sda), .ack_on(ack_on), .sda_oe_n(s_oe_n), .byte_seen(seen));
   task cmp(input string s, input logic [31:0] e, input logic [31:0] g);
      checks_done = checks_done + 1;
      if (g !== e)
      begin
         fails = fails + 1;
         $display("mismatch %s exp %h got %h", s, e, g);
      end
   endtask
   // hangs here are cut by the cycle ceiling
   task acc(input logic w, input logic [3:0] a, input logic [7:0] d);
      adr <= a;
      wr <= w;
      rd <= !w;
      wdat <= {24'h0, d};
      @(posedge clk);
      while (wreq !== 1'b0) @(posedge clk);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task step(input logic [7:0] d, input logic [7:0] c, input logic [7:0] code);
      acc(1'b1, `A_IRQ_MASK, (c == 8'h94) ? 8'h02 : 8'h05);
      acc(1'b1, `A_DATA, d);
      acc(1'b1, `A_CONTROL, c);
      while (irq !== 1'b1) @(posedge clk);
      acc(1'b0, `A_STATUS, 8'h00);
      cmp("status", {24'h0, code}, {q[31:8], q[7:0] & `CODE_MASK});
      acc(1'b1, `A_IRQ_STAT, 8'hFF);
   endtask
   task print_verdict;
      if (fails == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fails = fails + 1;
         print_verdict;
      end
   end
   initial
   begin
      rows = '{32'h00A40108, 32'hA0840118, 32'h3C840128, 32'hC3840030, 32'h00A40110, 32'hA2840020,
         32'h00B40108, 32'h5A840118, 32'h009401F8, 32'h00A40108, 32'hA5840140};
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      acc(1'b1, `A_POWER, 8'h00);
      for (int i = 0; i < 11; i = i + 1)
      begin
         ack_on <= rows[i][8];
         step(rows[i][31:24], rows[i][23:16], rows[i][7:0]);
         if (rows[i][23:16] == 8'h84) cmp("byte", {24'h0, rows[i][31:24]}, {24'h0, seen});
      end
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      acc(1'b0, `A_STATUS, 8'h00);
      cmp("idle", {24'h0, `ST_IDLE}, q);
      acc(1'b0, `A_POWER, 8'h00);
      cmp("power", {24'h0, `POWER_RST}, q);
      acc(1'b0, 4'hF, 8'h00);
      cmp("unmapped", 32'h0, q);
      acc(1'b1, `A_POWER, 8'h00);
      step(8'h00, 8'hA4, `ST_START);
      acc(1'b1, `A_CONTROL, 8'h04);
      repeat (40) @(posedge clk);
      acc(1'b0, `A_CONTROL, 8'h00);
      cmp("done", 32'h80, q & 32'h80);
      acc(1'b0, `A_STATUS, 8'h00);
      cmp("held", {24'h0, `ST_START}, q);
      cmp("irq clear", 32'h0, {31'h0, irq});
      rival <= 1'b1;
      step(8'h7F, 8'h84, `ST_ARB);
      cmp("sda free", 32'h1, {31'h0, sda_oe_n});
      rival <= 1'b0;
      acc(1'b1, `A_CONTROL, 8'h84);
      repeat (20) @(posedge clk);
      cmp("bus free", 32'h3, {30'h0, scl, sda_oe_n});
      cmp("drive zero", 32'h0, {30'h0, scl_o, sda_o});
      print_verdict;
   end
endmodule // two_wire_port_tb_top
